// ### src/rom_ctrl.sv
/*
  System-side controller that reads words from the clocked ROM.
  Assumes the ROM samples on the rising edge of rom_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rom_ctrl (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // User request
  input wire logic req_valid,
  input wire logic [rom_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_en,
  output logic req_ready,
  output logic rsp_valid,
  output logic [rom_pkg::DATA_W-1:0] rsp_data,
  // Pins
  rom_if.ctl pins
);
  import rom_pkg::*;

  typedef enum logic [1:0] {IDLE, SETUP, PULSE, CAPT} phase_type;
  typedef struct packed {
    phase_type ph;
    logic [CNT_W-1:0] cnt;
    addr_type addr;
    logic ce;
    logic clk_o;
    logic rsp;
    word_type data;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp = 1'b0;
    case (st_r.ph)
      IDLE: begin
        if (req_valid) begin
          st_nxt.addr = req_addr;
          st_nxt.ce = req_en;
          st_nxt.clk_o = 1'b0;
          st_nxt.cnt = CNT_ZERO;
          st_nxt.ph = SETUP;
        end
      end
      SETUP: begin
        st_nxt.cnt = st_r.cnt + CNT_ONE;
        if (st_r.cnt == CYC_LAST) begin
          st_nxt.clk_o = 1'b1;
          st_nxt.ph = PULSE;
        end
      end
      PULSE: begin
        st_nxt.clk_o = 1'b0;
        st_nxt.ph = CAPT;
      end
      CAPT: begin
        // The device loads its register on the rising edge of the pulse, so the
        // new word is only on the pins one cycle later.
        if (pins.data_oe) begin
          st_nxt.data = pins.data_out;
        end
        st_nxt.rsp = st_r.ce;
        st_nxt.ph = IDLE;
      end
      default: begin
        st_nxt.ph = IDLE;
      end
    endcase
    if (st_r.rsp) begin
      st_nxt.rsp = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req_ready = (st_r.ph == IDLE);
  assign rsp_valid = st_r.rsp;
  assign rsp_data = st_r.data;
  assign pins.addr = st_r.addr;
  assign pins.rom_clk = st_r.clk_o;
  assign pins.chip_en = st_r.ce;
endmodule : rom_ctrl
`default_nettype wire

// ### include/rom_pkg.sv
/*
  Shared constants and types for the clocked-output mask ROM and its controller.
  Assumes a single 50 MHz system clock shared by both ends.
*/
package rom_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 10;
  localparam int DEPTH = 256;
  localparam int CLK_PERIOD_NS = 20;
  // Shortest interval between two addresses, in ns.
  localparam int MIN_CYCLE_NS = 550;
  localparam int MIN_CYCLE_CYC = (MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(MIN_CYCLE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
  typedef logic [DATA_W-1:0] word_type;
  typedef logic [ADDR_W-1:0] addr_type;
  typedef word_type [DEPTH-1:0] table_type;
endpackage : rom_pkg

// ### include/rom_if.sv
/*
  Pin bundle between the ROM and the system logic driving it.
  Assumes the bench resolves the shared data wire from data_oe.
*/
`timescale 1ns/100ps
`default_nettype none
interface rom_if;
  import rom_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic rom_clk;
  logic chip_en;
  logic [DATA_W-1:0] data_out;
  logic data_oe;
  modport dev (input addr, input rom_clk, input chip_en, output data_out, output data_oe);
  modport ctl (output addr, output rom_clk, output chip_en, input data_out, input data_oe);
endinterface : rom_if
`default_nettype wire

// ### src/rom_device.sv
/*
  Mask ROM of 256 ten-bit words with a clocked output holding register.
  Assumes rom_clk, addr and chip_en are synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rom_device #(
  parameter rom_pkg::table_type CONTENTS = '0
) (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // Pins
  rom_if.dev pins
);
  import rom_pkg::*;

  // One select line per stored word, as the decoder drives the word lines.
  typedef logic [DEPTH-1:0] line_type;

  // Decode the address into a single active word line.
  function automatic line_type word_select(input addr_type a);
    line_type sel;
    sel = '0;
    sel[a] = 1'b1;
    return sel;
  endfunction : word_select

  // Read the matrix: only the word on the selected line reaches the buffer.
  function automatic word_type word_read(input table_type tbl, input line_type sel);
    word_type w;
    w = DATA_ZERO;
    for (int i = 0; i < DEPTH; i++) begin
      if (sel[i]) begin
        w = w | tbl[i];
      end
    end
    return w;
  endfunction : word_read

  // A pulse is seen when the clock pin is high now and was low one cycle ago.
  function automatic logic pulse_edge(input logic now, input logic last);
    return now && !last;
  endfunction : pulse_edge

  typedef struct packed {
    logic clk_d;
    word_type out;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_d = pins.rom_clk;
    // Capture on the rising edge of the pulse, regardless of enable.
    if (pulse_edge(pins.rom_clk, st_r.clk_d)) begin
      st_nxt.out = word_read(CONTENTS, word_select(pins.addr));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins.data_out = st_r.out;
  assign pins.data_oe = pins.chip_en;
endmodule : rom_device
`default_nettype wire

// ### sim/rom_asserts.sv
/* Pin checker for the ROM link; assumes one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module rom_asserts import rom_pkg::*; #(parameter table_type CONTENTS = '0) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic rom_clk,
  input wire logic chip_en,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  localparam logic [CNT_W-1:0] GAP_MAX = '1;
  localparam logic [CNT_W-1:0] MIN_GAP = CNT_W'(MIN_CYCLE_CYC);
  // Cycles since the address last changed, saturating at the top.
  logic [CNT_W-1:0] since_chg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      since_chg <= GAP_MAX;
    end else if ($changed(addr)) begin
      since_chg <= CNT_ONE;
    end else if (since_chg != GAP_MAX) begin
      since_chg <= since_chg + CNT_ONE;
    end
  end
  addr_space_a: assert property ($changed(addr) |-> since_chg >= MIN_GAP) else $error("space");
  setup_time_a: assert property ($rose(rom_clk) |-> since_chg >= MIN_GAP) else $error("setup");
  float_off_a: assert property (!chip_en |-> !data_oe) else $error("oe");
  drive_on_a: assert property ($rose(chip_en) |-> data_oe) else $error("on");
  word_hold_a: assert property (!$rose(rom_clk) |=> $stable(data_out)) else $error("hold");
  word_load_a: assert property ($rose(rom_clk) |=> data_out == CONTENTS[$past(addr)])
    else $error("load");
  one_pulse_a: assert property ($rose(rom_clk) |=> !rom_clk) else $error("pulse");
  setup_low_a: assert property ($changed(addr) |-> !rom_clk[*8]) else $error("setup");
  addr_gap_a: assert property ($changed(addr) |=> $stable(addr)[*8]) else $error("gap");
  addr_held_a: assert property ($rose(rom_clk) |-> $stable(addr)) else $error("held");
  cover property ($rose(rom_clk) && !chip_en);
  cover property ($rose(chip_en));
  cover property ($fell(chip_en));
  cover property ($rose(rom_clk) && chip_en);
endmodule : rom_asserts
`default_nettype wire

// ### sim/tb.sv
/* Bench: controller reads the ROM; needs rom_pkg, rom_if, rom_device, rom_ctrl and rom_asserts. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rom_pkg::*;
  function automatic table_type mk();
    for (int i = 0; i < DEPTH; i++) mk[i] = word_type'(i * 37 + 5);
  endfunction : mk
  localparam table_type TBL = mk();
  logic clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_en = 1'b0, req_ready, rsp_valid;
  addr_type req_addr = ADDR_ZERO;
  word_type rsp_data, e;
  word_type exp_q[$];
  int miscompares = 0, n_checks = 0, cyc = 0, seed = 66079;
  localparam int TIMEOUT_CYC = 3000;
  rom_if bus();
  rom_device #(.CONTENTS(TBL)) rom_device_inst(.clk, .reset_n, .pins(bus));
  rom_ctrl rom_ctrl_inst(.clk, .reset_n, .req_valid, .req_addr, .req_en, .req_ready,
    .rsp_valid, .rsp_data, .pins(bus));
  rom_asserts #(.CONTENTS(TBL)) rom_asserts_inst(.clk, .reset_n, .addr(bus.addr),
    .rom_clk(bus.rom_clk), .chip_en(bus.chip_en), .data_out(bus.data_out),
    .data_oe(bus.data_oe));
  always #10 clk = ~clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  always @(negedge clk) begin
    cyc++;
    if (cyc == TIMEOUT_CYC) begin
      miscompares++;
      print_verdict();
    end else if (rsp_valid) begin
      n_checks++;
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[ERR] %0t %h %h", $time, rsp_data, DATA_ZERO);
      end else begin
        e = exp_q.pop_front();
        if (rsp_data !== e) begin
          miscompares++;
          $display("[ERR] %0t %h %h", $time, rsp_data, e);
        end
      end
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    for (int n = 0; n < 40; n++) begin
      while (!req_ready) @(negedge clk);
      {req_en, req_addr} = 9'($random(seed));
      req_valid = 1'b1;
      if (req_en) exp_q.push_back(TBL[req_addr]);
      @(negedge clk);
      req_valid = 1'b0;
    end
    repeat (40) @(negedge clk);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("[ERR] %0t %h %h", $time, exp_q.size(), 0);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
